// [rtl/cct_timer.sv]
// Cascadable 16-bit compare timer with byte-wide CPU access.
// Assumes a same-clock byte bus master; pins and sub-clock are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module cct_timer
  import cct_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Peripheral byte bus
  input  wire logic [2:0] busAddr,
  input  wire logic       busWrite,
  input  wire logic       busRead,
  input  wire logic [7:0] busWdata,
  output logic      [7:0] busRdata,
  // Interrupt request and enable
  input  wire logic       timerIrqEnable,
  input  wire logic       irqReqWrite,
  output logic            irqRequestFlag,
  output logic            irqToCpu,
  // Count sources and power state
  input  wire logic       eventCountPin,
  input  wire logic       eventEdgeSelect,
  input  wire logic       subClockQuarter,
  input  wire cct_power_e powerMode,
  // Toggle pins
  output logic            upperTogglePin,
  output logic            lowerTogglePin
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic [1:0] rstPipe_reg;
  logic       rstSync_n;
  logic [2:0] evtSync_reg;
  logic [2:0] subSync_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_reg <= 2'b00;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end

  assign rstSync_n = rstPipe_reg[1];

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      evtSync_reg <= 3'b000;
      subSync_reg <= 3'b000;
    end else begin
      evtSync_reg <= {evtSync_reg[1:0], eventCountPin};
      subSync_reg <= {subSync_reg[1:0], subClockQuarter}; // RULE_20
    end
  end

  logic evtTick;
  logic subTick;

  // Bit 1 is the second stage; bit 2 only remembers it for edges
  assign evtTick = eventEdgeSelect ? (evtSync_reg[1] & ~evtSync_reg[2])
                                   : (~evtSync_reg[1] & evtSync_reg[2]);
  assign subTick = subSync_reg[1] & ~subSync_reg[2]; // RULE_20

  logic tickDiv4;
  logic tickDiv16;
  logic tickDiv32;

  cct_prescaler u_prescaler (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .tickDiv4  (tickDiv4),
    .tickDiv16 (tickDiv16),
    .tickDiv32 (tickDiv32)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0] cntLo_reg;
  logic [7:0] cntHi_reg;
  logic [15:0] match_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] stat_reg;
  logic [7:0] stage_reg;
  logic [15:0] count;

  assign count = {cntHi_reg, cntLo_reg};

  logic regWriteOk;
  logic halted;
  logic subOnly;
  logic split;
  logic wrCtrl, wrStat, wrCntHi, wrCntLo, wrCmpHi, wrCmpLo;
  logic rdCntHi;

  // CPU register writes only take effect in active or subactive mode
  assign regWriteOk = (powerMode == PM_ACTIVE) ||
                      (powerMode == PM_SUBACT); // RULE_22
  assign halted  = (powerMode == PM_STANDBY) ||
                   (powerMode == PM_MODSTBY); // RULE_22
  assign subOnly = (powerMode == PM_WATCH) || (powerMode == PM_SUBACT) ||
                   (powerMode == PM_SUBSLP);
  assign split   = ctrl_reg[CTRL_SPLIT]; // RULE_21 RULE_25

  assign wrCtrl  = busWrite && regWriteOk && (busAddr == IDX_CTRL);
  assign wrStat  = busWrite && regWriteOk && (busAddr == IDX_STAT);
  assign wrCntHi = busWrite && regWriteOk && (busAddr == IDX_CNT_HI);
  assign wrCntLo = busWrite && regWriteOk && (busAddr == IDX_CNT_LO);
  assign wrCmpHi = busWrite && regWriteOk && (busAddr == IDX_CMP_HI);
  assign wrCmpLo = busWrite && regWriteOk && (busAddr == IDX_CMP_LO);
  assign rdCntHi = busRead && (busAddr == IDX_CNT_HI);

  ////////////////////////////////////////////////////////////////////////////
  // Count clock selection

  function automatic logic selTick(input logic [2:0] sel,
                                   input logic       ext);
    logic t;
    t = 1'b0;
    case (sel)
      SEL_DIV32:  t = tickDiv32;  // RULE_24
      SEL_DIV16:  t = tickDiv16;
      SEL_DIV4:   t = tickDiv4;
      SEL_SUB:    t = subTick;
      SEL_PROHIB: t = 1'b0;
      default:    t = ext;        // RULE_09
    endcase
    // Watch, subactive and subsleep only run from the sub-clock; standby stops all
    return t && !halted && (!subOnly || sel == SEL_SUB); // RULE_22
  endfunction

  logic [2:0] lowSel;
  logic [2:0] highSel;
  logic lowTick;
  logic lowWrap;
  logic highTick;

  assign lowSel   = ctrl_reg[CTRL_CKSL +: 3];
  assign highSel  = ctrl_reg[CTRL_CKSH +: 3];
  // Processes, so that the tick and mode reads inside the function wake them
  always_comb lowTick = selTick(lowSel, evtTick); // RULE_09
  assign lowWrap  = lowTick && (cntLo_reg == HALF_MAX);
  always_comb highTick = split ? selTick(highSel, 1'b0) : lowWrap; // RULE_25

  ////////////////////////////////////////////////////////////////////////////
  // Match and overflow events

  logic lowEq;
  logic highEq;
  logic matchH;
  logic matchL;
  logic clrHi;
  logic clrLo;
  logic ovfHEvt;
  logic ovfLEvt;

  assign lowEq  = cntLo_reg == match_reg[7:0];
  assign highEq = cntHi_reg == match_reg[15:8];

  // Lower match byte write replaces the tick match by its own equality
  always_comb begin
    if (split) begin
      matchH = highTick && highEq; // RULE_21
      matchL = wrCmpLo ? (busWdata == cntLo_reg)
                       : (lowTick && lowEq); // RULE_16 RULE_17
    end else begin
      matchH = wrCmpLo ? ({stage_reg, busWdata} == count) // RULE_16
                       : (lowTick && lowEq && highEq); // RULE_10 RULE_17
      matchL = 1'b0;
    end
  end

  assign clrHi   = matchH && stat_reg[STAT_CLEAR_ON_MATCH_UPPER]; // RULE_12
  assign clrLo   = split ? (matchL && stat_reg[STAT_CCLRL]) : clrHi;
  assign ovfHEvt = highTick && (cntHi_reg == HALF_MAX) &&
                   !(split ? wrCntHi : wrCntLo); // RULE_18 RULE_19
  assign ovfLEvt = split && lowWrap && !wrCntLo; // RULE_19

  ////////////////////////////////////////////////////////////////////////////
  // Counter halves

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cntLo_reg <= CNT_RST[7:0]; // RULE_08
    end else if (wrCntLo) begin
      cntLo_reg <= busWdata; // RULE_05 RULE_04
    end else if (clrLo) begin
      cntLo_reg <= HALF_ZERO; // RULE_12
    end else if (lowTick) begin
      cntLo_reg <= cntLo_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cntHi_reg <= CNT_RST[15:8]; // RULE_08
    end else if (split && wrCntHi) begin
      cntHi_reg <= busWdata; // RULE_04
    end else if (!split && wrCntLo) begin
      cntHi_reg <= stage_reg; // RULE_05 RULE_03
    end else if (clrHi) begin
      cntHi_reg <= HALF_ZERO; // RULE_12
    end else if (highTick) begin
      cntHi_reg <= cntHi_reg + 1'b1; // RULE_25
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared byte stage and match word

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stage_reg <= HALF_ZERO;
    end else if (!split && (wrCntHi || wrCmpHi)) begin
      stage_reg <= busWdata; // RULE_02 RULE_05 RULE_26
    end else if (!split && rdCntHi) begin
      stage_reg <= cntLo_reg; // RULE_06 RULE_26
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      match_reg <= CMP_RST; // RULE_08
    end else if (wrCmpLo) begin
      match_reg <= {split ? match_reg[15:8] : stage_reg, busWdata}; // RULE_05
    end else if (split && wrCmpHi) begin
      match_reg[15:8] <= busWdata; // RULE_04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and status bytes

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctrl_reg <= CTRL_RST; // RULE_08
    end else if (wrCtrl) begin
      ctrl_reg <= busWdata;
    end
  end

  // Flags clear on a written zero; a same-cycle event wins
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stat_reg <= STAT_RST; // RULE_08
    end else begin
      if (wrStat) begin
        stat_reg[STAT_UPPER_OVERFLOW_IRQ_ENABLE] <= busWdata[STAT_UPPER_OVERFLOW_IRQ_ENABLE];
        stat_reg[STAT_CLEAR_ON_MATCH_UPPER] <= busWdata[STAT_CLEAR_ON_MATCH_UPPER];
        stat_reg[STAT_OVIEL] <= busWdata[STAT_OVIEL];
        stat_reg[STAT_CCLRL] <= busWdata[STAT_CCLRL];
      end
      stat_reg[STAT_UPPER_OVERFLOW_FLAG] <= ovfHEvt || (stat_reg[STAT_UPPER_OVERFLOW_FLAG] &&
                             !(wrStat && !busWdata[STAT_UPPER_OVERFLOW_FLAG])); // RULE_18
      stat_reg[STAT_UPPER_MATCH_FLAG] <= matchH || (stat_reg[STAT_UPPER_MATCH_FLAG] &&
                             !(wrStat && !busWdata[STAT_UPPER_MATCH_FLAG])); // RULE_10
      stat_reg[STAT_LOWER_OVERFLOW_FLAG] <= ovfLEvt || (stat_reg[STAT_LOWER_OVERFLOW_FLAG] &&
                             !(wrStat && !busWdata[STAT_LOWER_OVERFLOW_FLAG]));
      stat_reg[STAT_LOWER_MATCH_FLAG] <= matchL || (stat_reg[STAT_LOWER_MATCH_FLAG] &&
                             !(wrStat && !busWdata[STAT_LOWER_MATCH_FLAG])); // RULE_10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request, pins and read data

  logic irqSet;

  assign irqSet = matchH || (ovfHEvt && stat_reg[STAT_UPPER_OVERFLOW_IRQ_ENABLE]); // RULE_18

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irqRequestFlag <= 1'b0;
    end else if (irqSet) begin
      irqRequestFlag <= 1'b1; // RULE_23 RULE_11
    end else if (irqReqWrite && irqRequestFlag) begin
      irqRequestFlag <= 1'b0; // RULE_23
    end
  end

  assign irqToCpu = irqRequestFlag && timerIrqEnable; // RULE_11 RULE_18

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      upperTogglePin <= 1'b0;
    end else if (wrCtrl) begin
      upperTogglePin <= busWdata[CTRL_UPPER_OUTPUT_LEVEL]; // RULE_13 RULE_14
    end else if (matchH) begin
      upperTogglePin <= ~upperTogglePin; // RULE_11
    end
  end

  // Outside split mode the lower pin only follows its level bit
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lowerTogglePin <= 1'b0;
    end else if (wrCtrl) begin
      lowerTogglePin <= busWdata[CTRL_TOLL];
    end else if (split && matchL) begin
      lowerTogglePin <= ~lowerTogglePin; // RULE_15 RULE_21
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      busRdata <= HALF_ZERO;
    end else if (busRead) begin
      case (busAddr)
        IDX_CTRL:   busRdata <= ctrl_reg;
        IDX_STAT:   busRdata <= stat_reg;
        IDX_CNT_HI: busRdata <= cntHi_reg; // RULE_06 RULE_01
        IDX_CNT_LO: busRdata <= split ? cntLo_reg : stage_reg; // RULE_06
        IDX_CMP_HI: busRdata <= match_reg[15:8]; // RULE_07
        IDX_CMP_LO: busRdata <= match_reg[7:0]; // RULE_07
        default:    busRdata <= HALF_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSync_n);

  word_load_a: assert property ( // RULE_05
    wrCntLo && !split |=> cntHi_reg == $past(stage_reg) &&
                          cntLo_reg == $past(busWdata))
    else $error("counter word load mismatch");

  read_stage_a: assert property ( // RULE_06
    rdCntHi && !split |=> stage_reg == $past(cntLo_reg) &&
                          busRdata == $past(cntHi_reg))
    else $error("upper counter read did not stage lower half");

  match_direct_a: assert property ( // RULE_07
    busRead && busAddr == IDX_CMP_LO |=> busRdata == $past(match_reg[7:0]))
    else $error("match lower byte not read directly");

  level_wins_a: assert property ( // RULE_14
    wrCtrl |=> upperTogglePin == $past(busWdata[CTRL_UPPER_OUTPUT_LEVEL]))
    else $error("control write lost to match toggle");

  pin_toggle_a: assert property ( // RULE_11
    matchH && !wrCtrl |=> upperTogglePin != $past(upperTogglePin)
                          && irqRequestFlag)
    else $error("match did not toggle pin and request irq");

  match_clear_a: assert property ( // RULE_12
    clrHi && !split && !wrCntLo |=> count == CNT_RST)
    else $error("clear on match failed");

  no_tick_a: assert property ( // RULE_17
    !split && !lowTick && !wrCmpLo |-> !matchH ##1 !$rose(stat_reg[STAT_UPPER_MATCH_FLAG]))
    else $error("match without low count tick");

  ovf_flag_a: assert property ( // RULE_18
    !split && lowTick && count == CMP_RST && !wrCntLo && !clrLo
    |=> stat_reg[STAT_UPPER_OVERFLOW_FLAG] && count == CNT_RST)
    else $error("wrap did not set overflow flag");

  halt_hold_a: assert property ( // RULE_22
    halted [*2] |-> $stable(count))
    else $error("counter moved in standby");

  irq_clear_a: assert property ( // RULE_23
    irqRequestFlag && irqReqWrite && !irqSet |=> !irqRequestFlag)
    else $error("irq request flag not cleared");

endmodule

`default_nettype wire

// [rtl/cct_pkg.sv]
// Constants, field layout and power modes of the compare timer.
// Assumes a byte-wide peripheral bus and one 100 MHz system clock.
//
// Function
// RULE_01: Counter word and match word are 16-bit, CPU readable and writable.
// RULE_02: Every CPU write to either word, and every counter read, goes through one byte stage.
// RULE_03: Software accesses words upper byte first, then lower byte.
// RULE_04: In split mode byte halves are accessed directly in any order.
// RULE_05: Upper write fills stage; lower write loads stage and byte together.
// RULE_06: Upper counter read returns upper half and copies lower half to stage.
// RULE_07: Match word bytes are read directly, never through the stage.
// RULE_08: Reset gives counter 0000, match ffff, control and status 00.
// RULE_09: Low clock select picks prescaler, quarter sub-clock or event edge.
// RULE_10: Full 16-bit equality sets upper match flag; low half sets lower.
// RULE_11: Upper match requests interrupt and toggles the upper pin together.
// RULE_12: With clear-on-match set the counter clears on a match.
// RULE_13: Upper output level bit sets the upper pin level.
// RULE_14: Control write beats a coinciding match toggle on the upper pin.
// RULE_15: Lower pin is unused as timer output in 16-bit mode.
// RULE_16: Lower match write suppresses coinciding match; equal value matches.
// RULE_17: Matches are issued only on low-half count ticks.
// RULE_18: Wrap ffff to 0000 sets overflow; irq needs both enables.
// RULE_19: Lower counter write coinciding with overflow drops the overflow.
// RULE_20: Quarter sub-clock is resynchronised to the system clock.
// RULE_21: Counter may run as two independent 8-bit timers.
// RULE_22: Registers held outside active modes; counter halts in standby.
// RULE_23: Irq request flag sets on events, clears by writing one.
// RULE_24: Select codes: 0xx event, 011 prohibited, 1xx prescaler or sub.
// RULE_25: Upper select bit 2 splits; clear chains upper on lower overflow.
// RULE_26: One stage shared by both words; interleaving corrupts transfers.

package cct_pkg;

  // Register indices on the byte bus
  localparam logic [2:0] IDX_CTRL   = 3'h0;
  localparam logic [2:0] IDX_STAT   = 3'h1;
  localparam logic [2:0] IDX_CNT_HI = 3'h2;
  localparam logic [2:0] IDX_CNT_LO = 3'h3;
  localparam logic [2:0] IDX_CMP_HI = 3'h4;
  localparam logic [2:0] IDX_CMP_LO = 3'h5;

  // Reset values
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CMP_RST  = 16'hffff;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  STAT_RST = 8'h00;
  localparam logic [7:0]  HALF_MAX = 8'hff;
  localparam logic [7:0]  HALF_ZERO = 8'h00;

  // Control byte fields
  localparam int CTRL_UPPER_OUTPUT_LEVEL  = 7;
  localparam int CTRL_SPLIT = 6;
  localparam int CTRL_CKSH  = 4;
  localparam int CTRL_TOLL  = 3;
  localparam int CTRL_CKSL  = 0;

  // Status byte fields
  localparam int STAT_UPPER_OVERFLOW_FLAG  = 7;
  localparam int STAT_UPPER_MATCH_FLAG  = 6;
  localparam int STAT_UPPER_OVERFLOW_IRQ_ENABLE = 5;
  localparam int STAT_CLEAR_ON_MATCH_UPPER = 4;
  localparam int STAT_LOWER_OVERFLOW_FLAG  = 3;
  localparam int STAT_LOWER_MATCH_FLAG  = 2;
  localparam int STAT_OVIEL = 1;
  localparam int STAT_CCLRL = 0;

  // Clock select codes
  localparam logic [2:0] SEL_PROHIB = 3'h3;
  localparam logic [2:0] SEL_DIV32  = 3'h4;
  localparam logic [2:0] SEL_DIV16  = 3'h5;
  localparam logic [2:0] SEL_DIV4   = 3'h6;
  localparam logic [2:0] SEL_SUB    = 3'h7;

  // Prescaler taps, as counter bit counts
  localparam int PRE_W      = 5;
  localparam int DIV4_BITS  = 2;
  localparam int DIV16_BITS = 4;
  localparam int DIV32_BITS = 5;

  typedef enum logic [6:0] {
    PM_ACTIVE  = 7'h01,
    PM_SLEEP   = 7'h02,
    PM_WATCH   = 7'h04,
    PM_SUBACT  = 7'h08,
    PM_SUBSLP  = 7'h10,
    PM_STANDBY = 7'h20,
    PM_MODSTBY = 7'h40
  } cct_power_e;

endpackage

// [rtl/cct_prescaler.sv]
// System clock prescaler giving one-cycle enables at /4, /16 and /32.
// Assumes the synchronised reset of the timer top.
`timescale 1ns/1ps
`default_nettype none

module cct_prescaler
  import cct_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstSync_n,
  // Enables
  output logic      tickDiv4,
  output logic      tickDiv16,
  output logic      tickDiv32
);

  logic [PRE_W-1:0] preCnt_reg;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      preCnt_reg <= '0;
    end else begin
      preCnt_reg <= preCnt_reg + 1'b1;
    end
  end

  assign tickDiv4  = &preCnt_reg[DIV4_BITS-1:0];
  assign tickDiv16 = &preCnt_reg[DIV16_BITS-1:0];
  assign tickDiv32 = &preCnt_reg[DIV32_BITS-1:0];

endmodule

`default_nettype wire

// [test/cct_cpu_model.sv]
// CPU model on the byte-wide peripheral bus of the compare timer.
// Assumes the bench calls one task at a time, clocked by clk_sys.
`timescale 1ns/1ps
`default_nettype none

module cct_cpu_model (
  // Clock
  input  wire logic       clk_sys,
  // Peripheral byte bus
  output logic      [2:0] busAddr,
  output logic            busWrite,
  output logic            busRead,
  output logic      [7:0] busWdata,
  input  wire logic [7:0] busRdata
);
  initial begin
    busAddr  = 3'h7;
    busWrite = 1'b0;
    busRead  = 1'b0;
    busWdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte write; data is inverted once released so stale bytes never match
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busAddr  <= a;
    busWdata <= d;
    busWrite <= 1'b1;
    @(posedge clk_sys);
    busWrite <= 1'b0;
    busWdata <= ~d;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk_sys);
    busRead <= 1'b0;
    #1 d = busRdata;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Word access, upper byte first
  task automatic wr16(input logic [2:0] hi, input logic [15:0] v);
    wr(hi, v[15:8]);
    wr(hi + 3'h1, v[7:0]);
  endtask

  task automatic rd16(input logic [2:0] hi, output logic [15:0] v);
    rd(hi, v[15:8]);
    rd(hi + 3'h1, v[7:0]);
  endtask
endmodule
`default_nettype wire

// [test/cascadable_compare_timer_test.sv]
// Self-checking bench of the compare timer.
// Assumes the CPU model in test/ and the timer top with its package.
`timescale 1ns/1ps
`default_nettype none

module cascadable_compare_timer_test;
  import cct_pkg::*;

  logic       clk_sys         = 1'b0;
  logic       rst_n           = 1'b0;
  logic       timerIrqEnable  = 1'b1;
  logic       irqReqWrite     = 1'b0;
  logic       eventCountPin   = 1'b0;
  logic       eventEdgeSelect = 1'b1;
  logic       subClockQuarter = 1'b0;
  cct_power_e powerMode       = PM_ACTIVE;
  wire  [2:0] busAddr;
  wire        busWrite;
  wire        busRead;
  wire  [7:0] busWdata;
  logic [7:0] busRdata;
  logic       irqRequestFlag;
  logic       irqToCpu;
  logic       upperTogglePin;
  logic       lowerTogglePin;
  int         nFail           = 0;
  int         checks          = 0;

  always #5 clk_sys = ~clk_sys;

  cct_timer dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .busAddr(busAddr),
    .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata),
    .busRdata(busRdata), .timerIrqEnable(timerIrqEnable),
    .irqReqWrite(irqReqWrite), .irqRequestFlag(irqRequestFlag),
    .irqToCpu(irqToCpu), .eventCountPin(eventCountPin),
    .eventEdgeSelect(eventEdgeSelect), .subClockQuarter(subClockQuarter),
    .powerMode(powerMode), .upperTogglePin(upperTogglePin),
    .lowerTogglePin(lowerTogglePin)
  );

  cct_cpu_model cpu (
    .clk_sys(clk_sys), .busAddr(busAddr), .busWrite(busWrite),
    .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wait_irq(input int lim);
    int i;
    i = 0;
    while (irqRequestFlag !== 1'b1 && i < lim) begin
      @(posedge clk_sys);
      i++;
    end
    #1;
  endtask

  task automatic clear_irq();
    @(posedge clk_sys);
    irqReqWrite <= 1'b1;
    @(posedge clk_sys);
    irqReqWrite <= 1'b0;
    #1;
  endtask

  // Slow pulses on the event pin or on the quarter sub-clock
  task automatic pulse(input bit sub, input int n);
    repeat (n) begin
      if (sub) subClockQuarter <= 1'b1;
      else eventCountPin <= 1'b1;
      cyc(6);
      if (sub) subClockQuarter <= 1'b0;
      else eventCountPin <= 1'b0;
      cyc(6);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0]  b;
    logic [15:0] w;
    check("pinRst", 16'(upperTogglePin), 16'h0);
    cpu.rd(IDX_CTRL, b); check("ctrlRst", 16'(b), 16'(CTRL_RST));
    cpu.rd(IDX_STAT, b); check("statRst", 16'(b), 16'(STAT_RST));
    cpu.rd16(IDX_CNT_HI, w); check("cntRst", w, CNT_RST);
    cpu.rd16(IDX_CMP_HI, w); check("cmpRst", w, CMP_RST);
  endtask

  task automatic t_stage();
    logic [7:0]  b;
    logic [15:0] w;
    cpu.wr(IDX_CTRL, 8'h0b);
    #1 check("lowLvl", 16'(lowerTogglePin), 16'h1);
    cpu.wr16(IDX_CNT_HI, 16'haa55);
    cpu.rd16(IDX_CNT_HI, w); check("cntWord", w, 16'haa55);
    cpu.wr16(IDX_CMP_HI, 16'h1234);
    cpu.rd(IDX_CMP_LO, b); check("cmpLo", 16'(b), 16'h34);
    cpu.rd(IDX_CMP_HI, b); check("cmpHi", 16'(b), 16'h12);
    // Counter read between the bytes overwrites the staged upper byte
    cpu.wr(IDX_CNT_HI, 8'h77);
    cpu.rd(IDX_CNT_HI, b); check("cntHi", 16'(b), 16'haa);
    cpu.wr(IDX_CNT_LO, 8'h11);
    cpu.rd16(IDX_CNT_HI, w); check("stageMix", w, 16'h5511);
    cpu.wr(3'h6, 8'hff);
    cpu.rd(3'h6, b); check("unmapped", 16'(b), 16'h0);
  endtask

  task automatic t_match();
    logic [7:0]  b;
    logic [15:0] w;
    cpu.wr16(IDX_CNT_HI, 16'h0000);
    cpu.wr16(IDX_CMP_HI, 16'h0002);
    cpu.wr(IDX_STAT, 8'h10);
    cpu.wr(IDX_CTRL, 8'h06);
    wait_irq(60);
    check("irqFlag", 16'(irqRequestFlag), 16'h1);
    check("irqCpu", 16'(irqToCpu), 16'h1);
    check("pinTog", 16'(upperTogglePin), 16'h1);
    cyc(30);
    cpu.wr(IDX_CTRL, 8'h03);
    #1 check("pinLvl0", 16'(upperTogglePin), 16'h0);
    cpu.rd(IDX_STAT, b); check("upper_match_flag", 16'(b[STAT_UPPER_MATCH_FLAG]), 16'h1);
    cpu.rd16(IDX_CNT_HI, w); check("clr", 16'(w <= 16'h2), 16'h1);
    cpu.wr(IDX_CTRL, 8'h83);
    #1 check("pinLvl1", 16'(upperTogglePin), 16'h1);
    timerIrqEnable <= 1'b0;
    cyc(1);
    #1 check("irqMask", 16'(irqToCpu), 16'h0);
    timerIrqEnable <= 1'b1;
    clear_irq();
    check("irqClr", 16'(irqRequestFlag), 16'h0);
    cpu.wr(IDX_STAT, 8'h00);
  endtask

  task automatic t_overflow();
    logic [7:0] b;
    cpu.wr(IDX_CTRL, 8'h03);
    cpu.wr16(IDX_CMP_HI, 16'h1234);
    cpu.wr16(IDX_CNT_HI, 16'hfffe);
    cpu.wr(IDX_CTRL, 8'h06);
    cyc(20);
    cpu.rd(IDX_STAT, b); check("upper_overflow_flag", 16'(b[STAT_UPPER_OVERFLOW_FLAG]), 16'h1);
    check("ovNoIrq", 16'(irqRequestFlag), 16'h0);
    cpu.wr(IDX_CTRL, 8'h03);
    cpu.wr(IDX_STAT, 8'h20);
    cpu.wr16(IDX_CNT_HI, 16'hfffe);
    cpu.wr(IDX_CTRL, 8'h06);
    wait_irq(40);
    check("ovIrq", 16'(irqRequestFlag), 16'h1);
    cpu.wr(IDX_CTRL, 8'h03);
    clear_irq();
    cpu.wr(IDX_STAT, 8'h00);
  endtask

  task automatic t_count_src();
    logic [15:0] w;
    cpu.wr16(IDX_CNT_HI, 16'h00fe);
    cpu.wr(IDX_CTRL, 8'h00);
    pulse(1'b0, 3);
    cpu.rd16(IDX_CNT_HI, w); check("evRise", w, 16'h0101);
    eventEdgeSelect <= 1'b0;
    pulse(1'b0, 2);
    cpu.rd16(IDX_CNT_HI, w); check("evFall", w, 16'h0103);
    cpu.wr(IDX_CTRL, 8'h03);
    pulse(1'b0, 2);
    cpu.rd16(IDX_CNT_HI, w); check("prohib", w, 16'h0103);
    cpu.wr16(IDX_CNT_HI, 16'h0000);
    cpu.wr(IDX_CTRL, 8'h07);
    pulse(1'b1, 4);
    cpu.rd16(IDX_CNT_HI, w); check("subClk", w, 16'h0004);
    powerMode <= PM_WATCH;
    pulse(1'b1, 2);
    cpu.rd16(IDX_CNT_HI, w); check("watch", w, 16'h0006);
    powerMode <= PM_STANDBY;
    pulse(1'b1, 2);
    cpu.wr16(IDX_CNT_HI, 16'h0000);
    cpu.rd16(IDX_CNT_HI, w); check("standby", w, 16'h0006);
    powerMode <= PM_ACTIVE;
    cpu.wr(IDX_CTRL, 8'h03);
  endtask

  task automatic t_split_equal();
    logic [7:0] b;
    cpu.wr(IDX_CTRL, 8'h73);
    cpu.wr(IDX_CNT_LO, 8'h5a);
    cpu.wr(IDX_CNT_HI, 8'hc3);
    cpu.rd(IDX_CNT_LO, b); check("splitLo", 16'(b), 16'h5a);
    cpu.rd(IDX_CNT_HI, b); check("splitHi", 16'(b), 16'hc3);
    cpu.wr(IDX_CTRL, 8'h03);
    cpu.wr16(IDX_CMP_HI, 16'h0020);
    cpu.wr16(IDX_CNT_HI, 16'h0020);
    cyc(10);
    cpu.rd(IDX_STAT, b); check("noTick", 16'(b[STAT_UPPER_MATCH_FLAG]), 16'h0);
    cpu.wr16(IDX_CMP_HI, 16'h0020);
    cpu.rd(IDX_STAT, b); check("eqWrite", 16'(b[STAT_UPPER_MATCH_FLAG]), 16'h1);
  endtask

  // Split mode: lower half on /16 reaches its own match byte, upper on /32
  task automatic t_split_match();
    logic [7:0] b;
    cpu.wr(IDX_CTRL, 8'h73);
    cpu.wr(IDX_CNT_LO, 8'h00);
    cpu.wr(IDX_CMP_LO, 8'h02);
    cpu.wr(IDX_CTRL, 8'h45);
    cyc(60);
    cpu.rd(IDX_STAT, b); check("lower_match_flag", 16'(b[STAT_LOWER_MATCH_FLAG]), 16'h1);
    check("lowTog", 16'(lowerTogglePin), 16'h1);
    cpu.rd(IDX_CNT_HI, b); check("hiRun", 16'(b != 8'h00), 16'h1);
    cpu.wr(IDX_CTRL, 8'h03);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    nFail++;
    final_report();
  end

  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(5);
    t_reset();
    t_stage();
    t_match();
    t_overflow();
    t_count_src();
    t_split_equal();
    t_split_match();
    final_report();
  end
endmodule
`default_nettype wire
